/* File: logic/fpes_flash_ctrl.sv */
`timescale 1ns/1ps
`include "fpes_map.svh"
module fpes_flash_ctrl #(
  parameter int WRITE_CYCLES = `FPES_WRITE_NS / `FPES_CLK_NS,
  parameter int ERASE_CYCLES = `FPES_ERASE_NS / `FPES_CLK_NS
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rstn,
  // special function registers
  input  wire logic                       sfr_wr,
  input  wire logic [7:0]                 sfr_addr,
  input  wire logic [7:0]                 sfr_wdata,
  output logic      [7:0]                 sfr_rdata,
  // external move instructions
  input  wire logic                       xm_wr,
  input  wire logic                       xm_rd,
  input  wire logic [15:0]                xm_addr,
  input  wire logic [7:0]                 xm_wdata,
  output logic                            external_data_ram_wr,
  output logic                            external_data_ram_rd,
  // code move reads and executing address
  input  wire logic                       cm_rd,
  input  wire logic [15:0]                cm_addr,
  input  wire logic [15:0]                exec_pc,
  output logic      [7:0]                 cm_rdata,
  // instruction fetch
  input  wire logic [15:0]                fetch_addr,
  output logic      [7:0]                 fetch_data,
  // core control
  output logic                            cpu_stall,
  output logic                            irq_hold,
  output logic                            op_refused,
  // programming port
  input  wire fpes_pkg::fpes_jtag_req_type jtag_req,
  output logic      [7:0]                 jtag_rdata
);
  localparam int CNT_W = 22;

  logic [7:0]               mem [0:65535];
  logic [7:0]               scr [0:127];
  logic                     rst_q1;
  logic                     rst_q2;
  logic [7:0]               store_ctl;
  logic [7:0]               flash_ctl;
  logic [7:0]               software_access_limit;
  logic                     limit_taken;
  fpes_pkg::fpes_state_type state;
  fpes_pkg::fpes_op_type    op;
  fpes_pkg::fpes_op_type    next_op;
  logic [CNT_W-1:0]         cnt;
  logic [15:0]              ptr;
  logic                     walk_done;
  logic                     start;
  logic                     refuse;
  logic                     time_up;
  logic                     busy;
  logic                     program_store_write_en;
  logic                     program_store_erase_en;
  logic                     scratch_sector_select;
  logic                     flash_write_gate;
  logic [7:0]               flash_write_erase_lock;
  logic [7:0]               flash_read_lock;
  logic [15:0]              software_read_limit;
  logic                     sw_req;
  logic                     sw_limited;
  logic                     cm_limited;
  logic                     jt_wr_ok;
  logic                     jt_rd_ok;
  logic                     mem_we;
  logic                     scr_we;
  logic [15:0]              mem_wa;
  logic [7:0]               mem_wd;
  logic [7:0]               rd_byte;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  // control bit views
  assign program_store_write_en = store_ctl[`FPES_WR_EN_BIT];
  assign program_store_erase_en = store_ctl[`FPES_ER_EN_BIT];
  assign scratch_sector_select  = store_ctl[`FPES_SCR_SEL_BIT];
  assign flash_write_gate       = flash_ctl[`FPES_GATE_BIT];
  assign flash_write_erase_lock = mem[`FPES_WE_LOCK_ADDR];
  assign flash_read_lock        = mem[`FPES_RD_LOCK_ADDR];
  assign software_read_limit    = {software_access_limit, `FPES_LIMIT_LOW};
  assign busy      = (state != fpes_pkg::ST_IDLE);
  assign cpu_stall = busy;
  assign irq_hold  = busy;

  // store and flash control registers; only software clears the enables
  always_ff @(posedge sys_clk or negedge rst_q2)
  begin
    if (!rst_q2)
    begin
      store_ctl <= `FPES_STORE_CTL_RST;
      flash_ctl <= `FPES_FLASH_CTL_RST;
    end
    else if (sfr_wr && sfr_addr == `FPES_SFR_STORE_CTL)
      store_ctl <= sfr_wdata & `FPES_STORE_CTL_MASK;
    else if (sfr_wr && sfr_addr == `FPES_SFR_FLASH_CTL)
      flash_ctl <= sfr_wdata & `FPES_FLASH_CTL_MASK;
  end

  // access limit: later writes are lost, so firmware cannot move it back
  always_ff @(posedge sys_clk or negedge rst_q2)
  begin
    if (!rst_q2)
    begin
      software_access_limit <= `FPES_ACC_LIMIT_RST;
      limit_taken           <= 1'b0;
    end
    else if (sfr_wr && sfr_addr == `FPES_SFR_ACC_LIMIT && !limit_taken)
    begin
      software_access_limit <= sfr_wdata;
      limit_taken           <= 1'b1;
    end
  end

  // register read back, reserved bits zero
  always_ff @(posedge sys_clk or negedge rst_q2)
  begin
    if (!rst_q2)
      sfr_rdata <= 8'h00;
    else if (sfr_addr == `FPES_SFR_STORE_CTL)
      sfr_rdata <= store_ctl;
    else if (sfr_addr == `FPES_SFR_FLASH_CTL)
      sfr_rdata <= flash_ctl;
    else if (sfr_addr == `FPES_SFR_ACC_LIMIT)
      sfr_rdata <= software_access_limit;
    else
      sfr_rdata <= 8'h00;
  end

  // external move routing; reads never see flash
  assign external_data_ram_wr = xm_wr && !program_store_write_en;
  assign external_data_ram_rd = xm_rd;
  assign sw_req  = xm_wr && program_store_write_en;
  // code above the limit may not reach below it
  assign sw_limited = (exec_pc >= software_read_limit) &&
                      (xm_addr < software_read_limit);
  assign cm_limited = (exec_pc >= software_read_limit) &&
                      (cm_addr < software_read_limit);

  // port lock checks; lock bytes stay readable and clearable even when
  // locked, so more blocks can still be locked after block 7 is
  assign jt_wr_ok = jtag_req.scratch ? (|flash_write_erase_lock) :
    (flash_write_erase_lock[jtag_req.addr[15:13]] ||
     jtag_req.addr == `FPES_WE_LOCK_ADDR ||
     jtag_req.addr == `FPES_RD_LOCK_ADDR);
  assign jt_rd_ok = jtag_req.scratch ? (|flash_read_lock) :
    (flash_read_lock[jtag_req.addr[15:13]] ||
     jtag_req.addr == `FPES_WE_LOCK_ADDR ||
     jtag_req.addr == `FPES_RD_LOCK_ADDR);

  // request arbitration; the core wins a tie and the port request is lost
  always_comb
  begin
    start   = 1'b0;
    refuse  = 1'b0;
    next_op = '0;
    if (!busy && sw_req)
    begin
      next_op.scratch = scratch_sector_select;
      next_op.data    = xm_wdata;
      next_op.erase   = program_store_erase_en;
      next_op.addr    = xm_addr;
      next_op.last    = xm_addr;
      if (program_store_erase_en && scratch_sector_select)
      begin
        next_op.addr = `FPES_ALL_FIRST;
        next_op.last = `FPES_SCR_LAST;
      end
      else if (program_store_erase_en)
      begin
        next_op.addr = xm_addr & `FPES_PAGE_MASK;
        next_op.last = (xm_addr & `FPES_PAGE_MASK) | `FPES_PAGE_LAST;
      end
      if (!flash_write_gate || sw_limited)
        refuse = 1'b1;
      else if (program_store_erase_en && !scratch_sector_select &&
               (xm_addr & `FPES_PAGE_MASK) == `FPES_LOCK_PAGE)
        refuse = 1'b1;
      else
        start = 1'b1;
    end
    else if (!busy && (jtag_req.wr || jtag_req.erase))
    begin
      next_op.scratch = jtag_req.scratch;
      next_op.data    = jtag_req.data;
      next_op.erase   = jtag_req.erase;
      next_op.addr    = jtag_req.addr;
      next_op.last    = jtag_req.addr;
      start           = jt_wr_ok;
      refuse          = !jt_wr_ok;
      if (jtag_req.erase && !jtag_req.scratch &&
          (jtag_req.addr == `FPES_WE_LOCK_ADDR ||
           jtag_req.addr == `FPES_RD_LOCK_ADDR))
      begin
        next_op.addr = `FPES_ALL_FIRST;
        next_op.last = `FPES_ALL_LAST;
        start        = 1'b1;
        refuse       = 1'b0;
      end
      else if (jtag_req.erase && jtag_req.scratch)
      begin
        next_op.addr = `FPES_ALL_FIRST;
        next_op.last = `FPES_SCR_LAST;
      end
      else if (jtag_req.erase)
      begin
        next_op.addr = jtag_req.addr & `FPES_PAGE_MASK;
        next_op.last = (jtag_req.addr & `FPES_PAGE_MASK) | `FPES_PAGE_LAST;
      end
    end
  end

  // duration check; erase also waits for the byte walk to finish
  assign time_up = (state == fpes_pkg::ST_WRITE) ?
    (cnt >= CNT_W'(WRITE_CYCLES - 1)) :
    (cnt >= CNT_W'(ERASE_CYCLES - 1));

  // operation sequencer
  always_ff @(posedge sys_clk or negedge rst_q2)
  begin
    if (!rst_q2)
    begin
      state     <= fpes_pkg::ST_IDLE;
      op        <= '0;
      cnt       <= '0;
      ptr       <= 16'h0000;
      walk_done <= 1'b0;
    end
    else
    begin
      case (state)
        fpes_pkg::ST_IDLE:
        begin
          if (start)
          begin
            op        <= next_op;
            cnt       <= '0;
            ptr       <= next_op.addr;
            walk_done <= 1'b0;
            state     <= next_op.erase ? fpes_pkg::ST_ERASE :
                                         fpes_pkg::ST_WRITE;
          end
        end
        fpes_pkg::ST_WRITE:
        begin
          if (time_up)
            state <= fpes_pkg::ST_IDLE;
          else
            cnt <= cnt + 1'b1;
        end
        fpes_pkg::ST_ERASE:
        begin
          if (!walk_done)
          begin
            ptr       <= ptr + 1'b1;
            walk_done <= (ptr == op.last);
          end
          if (time_up && walk_done)
            state <= fpes_pkg::ST_IDLE;
          else if (!time_up)
            cnt <= cnt + 1'b1;
        end
        default:
          state <= fpes_pkg::ST_IDLE;
      endcase
    end
  end

  // refusal pulse
  always_ff @(posedge sys_clk or negedge rst_q2)
  begin
    if (!rst_q2)
      op_refused <= 1'b0;
    else
      op_refused <= refuse;
  end

  // array write port; a write lands at the end of its timed interval
  assign rd_byte = op.scratch ? scr[op.addr[6:0]] : mem[op.addr];
  always_comb
  begin
    mem_we = 1'b0;
    scr_we = 1'b0;
    mem_wa = op.addr;
    mem_wd = `FPES_ERASED;
    if (state == fpes_pkg::ST_WRITE && time_up)
    begin
      mem_wd = rd_byte & op.data;
      mem_we = !op.scratch;
      scr_we = op.scratch;
    end
    else if (state == fpes_pkg::ST_ERASE && !walk_done)
    begin
      mem_wa = ptr;
      mem_wd = `FPES_ERASED;
      mem_we = !op.scratch;
      scr_we = op.scratch;
    end
  end

  // flash cells hold no reset value
  always_ff @(posedge sys_clk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
    if (scr_we)
      scr[mem_wa[6:0]] <= mem_wd;
  end

  // code-move and fetch data; fetch never sees the scratch sector
  always_ff @(posedge sys_clk or negedge rst_q2)
  begin
    if (!rst_q2)
    begin
      cm_rdata   <= 8'h00;
      fetch_data <= 8'h00;
      jtag_rdata <= 8'h00;
    end
    else
    begin
      fetch_data <= mem[fetch_addr];
      if (cm_rd && cm_limited)
        cm_rdata <= `FPES_BLOCKED;
      else if (cm_rd)
        cm_rdata <= scratch_sector_select ? scr[cm_addr[6:0]] :
                                            mem[cm_addr];
      if (jtag_req.rd && !jt_rd_ok)
        jtag_rdata <= `FPES_BLOCKED;
      else if (jtag_req.rd)
        jtag_rdata <= jtag_req.scratch ? scr[jtag_req.addr[6:0]] :
                                         mem[jtag_req.addr];
    end
  end

  property p_gate;
    @(posedge sys_clk) disable iff (!rst_q2)
    (sw_req && !busy && !flash_write_gate) |=> !busy;
  endproperty
  a_gate: assert property (p_gate) else $error("write without gate");

  property p_route;
    @(posedge sys_clk) disable iff (!rst_q2)
    xm_wr |-> (external_data_ram_wr != program_store_write_en);
  endproperty
  a_route: assert property (p_route) else $error("write routing");

  property p_xread;
    @(posedge sys_clk) disable iff (!rst_q2)
    xm_rd |-> external_data_ram_rd;
  endproperty
  a_xread: assert property (p_xread) else $error("ram read lost");

  property p_hold_en;
    @(posedge sys_clk) disable iff (!rst_q2)
    (program_store_write_en && !sfr_wr) |=> program_store_write_en;
  endproperty
  a_hold_en: assert property (p_hold_en) else $error("enable fell");

  property p_once;
    @(posedge sys_clk) disable iff (!rst_q2)
    limit_taken |=> $stable(software_access_limit);
  endproperty
  a_once: assert property (p_once) else $error("limit rewritten");

  property p_stall;
    @(posedge sys_clk) disable iff (!rst_q2)
    start |=> (cpu_stall && irq_hold) [*2];
  endproperty
  a_stall: assert property (p_stall) else $error("no stall");

  property p_limit_rd;
    @(posedge sys_clk) disable iff (!rst_q2)
    (cm_rd && cm_limited) |=> cm_rdata == `FPES_BLOCKED;
  endproperty
  a_limit_rd: assert property (p_limit_rd) else $error("limit leak");

  property p_lock_page;
    @(posedge sys_clk) disable iff (!rst_q2)
    (sw_req && !busy && program_store_erase_en && !scratch_sector_select &&
     (xm_addr & `FPES_PAGE_MASK) == `FPES_LOCK_PAGE) |=> op_refused && !busy;
  endproperty
  a_lock_page: assert property (p_lock_page) else $error("lock erase");

  property p_clear_only;
    @(posedge sys_clk) disable iff (!rst_q2)
    (state == fpes_pkg::ST_WRITE && mem_we) |=>
      (mem[$past(mem_wa)] & ~$past(rd_byte)) == 8'h00;
  endproperty
  a_clear_only: assert property (p_clear_only) else $error("bit set");

  property p_jt_rd;
    @(posedge sys_clk) disable iff (!rst_q2)
    (jtag_req.rd && !jt_rd_ok) |=> jtag_rdata == `FPES_BLOCKED;
  endproperty
  a_jt_rd: assert property (p_jt_rd) else $error("locked read");

  c_write: cover property (@(posedge sys_clk) state == fpes_pkg::ST_WRITE);
  c_erase: cover property (@(posedge sys_clk) state == fpes_pkg::ST_ERASE);
  c_refuse: cover property (@(posedge sys_clk) op_refused);
  c_done: cover property (@(posedge sys_clk) $fell(busy));
endmodule

/* File: logic/fpes_map.svh */
`ifndef FPES_MAP_SVH
`define FPES_MAP_SVH
// special function register addresses
`define FPES_SFR_STORE_CTL 8'h8F
`define FPES_SFR_FLASH_CTL 8'hB6
`define FPES_SFR_ACC_LIMIT 8'hB7
// reset values and writable masks
`define FPES_STORE_CTL_RST 8'h00
`define FPES_FLASH_CTL_RST 8'h80
`define FPES_FLASH_CTL_MASK 8'hC1
`define FPES_STORE_CTL_MASK 8'h07
`define FPES_ACC_LIMIT_RST 8'h00
// bit positions
`define FPES_WR_EN_BIT 0
`define FPES_ER_EN_BIT 1
`define FPES_SCR_SEL_BIT 2
`define FPES_GATE_BIT 0
// flash map
`define FPES_WE_LOCK_ADDR 16'hFDFE
`define FPES_RD_LOCK_ADDR 16'hFDFF
`define FPES_PAGE_MASK 16'hFE00
`define FPES_PAGE_LAST 16'h01FF
`define FPES_LOCK_PAGE 16'hFC00
`define FPES_ALL_FIRST 16'h0000
`define FPES_ALL_LAST 16'hFDFF
`define FPES_SCR_LAST 16'h007F
`define FPES_LIMIT_LOW 8'h00
`define FPES_ERASED 8'hFF
`define FPES_BLOCKED 8'h00
// timing
`define FPES_CLK_NS 5
`define FPES_WRITE_NS 50000
`define FPES_ERASE_NS 12000000
`endif

/* File: logic/fpes_pkg.sv */
package fpes_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_ERASE} fpes_state_type;
  // one flash operation: byte write or range erase
  typedef struct packed {
    logic        scratch;
    logic        erase;
    logic [15:0] addr;
    logic [15:0] last;
    logic [7:0]  data;
  } fpes_op_type;
  // programming port request, all strobes one cycle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        erase;
    logic        scratch;
    logic [15:0] addr;
    logic [7:0]  data;
  } fpes_jtag_req_type;
endpackage

/* File: testbench/fpes_flash_ctrl_tb.sv */
`timescale 1ns/1ps
`include "fpes_map.svh"
`define CHK(nm, exp, got) \
  begin compares++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module fpes_flash_ctrl_tb;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        sfr_wr = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic        xm_wr = 1'b0;
  logic        xm_rd = 1'b0;
  logic [15:0] xm_addr = 16'h0000;
  logic [7:0]  xm_wdata = 8'h00;
  logic        external_data_ram_wr;
  logic        external_data_ram_rd;
  logic        cm_rd = 1'b0;
  logic [15:0] cm_addr = 16'h0000;
  logic [15:0] exec_pc = 16'h0000;
  logic [7:0]  cm_rdata;
  logic [15:0] fetch_addr = 16'h0000;
  logic [7:0]  fetch_data;
  logic        cpu_stall;
  logic        irq_hold;
  logic        op_refused;
  logic [7:0]  jtag_rdata;
  int          err_total = 0;
  int          compares = 0;
  logic        jt_scr = 1'b0;
  fpes_pkg::fpes_jtag_req_type jtag_req;

  // 200 MHz system clock
  always #2.5 sys_clk = ~sys_clk;

  fpes_jtag_host host (
    .sys_clk  (sys_clk),
    .jtag_req (jtag_req)
  );

  // short counts keep the full-array erase inside the run budget
  fpes_flash_ctrl #(.WRITE_CYCLES(8), .ERASE_CYCLES(16)) dut (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .sfr_wr     (sfr_wr),
    .sfr_addr   (sfr_addr),
    .sfr_wdata  (sfr_wdata),
    .sfr_rdata  (sfr_rdata),
    .xm_wr      (xm_wr),
    .xm_rd      (xm_rd),
    .xm_addr    (xm_addr),
    .xm_wdata   (xm_wdata),
    .external_data_ram_wr    (external_data_ram_wr),
    .external_data_ram_rd    (external_data_ram_rd),
    .cm_rd      (cm_rd),
    .cm_addr    (cm_addr),
    .exec_pc    (exec_pc),
    .cm_rdata   (cm_rdata),
    .fetch_addr (fetch_addr),
    .fetch_data (fetch_data),
    .cpu_stall  (cpu_stall),
    .irq_hold   (irq_hold),
    .op_refused (op_refused),
    .jtag_req   (jtag_req),
    .jtag_rdata (jtag_rdata)
  );

  // verdict and end of run
  task automatic summarize();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // register write: one-cycle strobe
  task automatic sfr_put(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask

  // register read lands on the first rising edge after the address is set, checked two falling edges later
  task automatic sfr_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    sfr_addr = a;
    repeat (2) @(negedge sys_clk);
    `CHK("sfr_rdata", e, sfr_rdata)
  endtask

  // code-move read from a given executing address
  task automatic cm_chk(input logic [15:0] a, input logic [15:0] pc,
                        input logic [7:0] e);
    @(negedge sys_clk);
    cm_rd = 1'b1;
    cm_addr = a;
    exec_pc = pc;
    @(negedge sys_clk);
    cm_rd = 1'b0;
    `CHK("cm_rdata", e, cm_rdata)
  endtask

  task automatic jt_chk(input logic [15:0] a, input logic [7:0] e);
    host.send('{rd:1'b1, wr:1'b0, erase:1'b0, scratch:jt_scr, addr:a,
                data:8'h00});
    `CHK("jtag_rdata", e, jtag_rdata)
  endtask

  // flash write or erase from the core or the port; n is the expected
  // busy length, zero meaning the request must be refused
  task automatic op(input logic jt, input logic er, input logic [15:0] a,
                    input logic [7:0] d, input int n);
    int c;
    c = 0;
    if (jt)
      host.send('{rd:1'b0, wr:~er, erase:er, scratch:jt_scr, addr:a, data:d});
    else
    begin
      @(negedge sys_clk);
      xm_wr = 1'b1;
      xm_addr = a;
      xm_wdata = d;
      #1 `CHK("external_data_ram_wr", 1'b0, external_data_ram_wr)
      @(negedge sys_clk);
      xm_wr = 1'b0;
    end
    `CHK("op_refused", (n == 0), op_refused)
    // interrupts must stay held throughout the stall window
    while (cpu_stall === 1'b1 && c < 70000)
    begin
      `CHK("irq_hold", 1'b1, irq_hold)
      c++;
      @(negedge sys_clk);
    end
    if (c >= 70000)
    begin
      err_total++;
      $display("ERROR busy expected %0d seen %0d", n, c);
      summarize();
    end
    `CHK("busy", n, c)
  endtask

  initial
  begin
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    sfr_chk(`FPES_SFR_STORE_CTL, 8'h00);
    sfr_chk(`FPES_SFR_FLASH_CTL, 8'h80);
    sfr_chk(`FPES_SFR_ACC_LIMIT, 8'h00);
    sfr_chk(8'h10, 8'h00);
    $display("test reset values done");
    op(1'b1, 1'b1, 16'hFDFE, 8'h00, 65025);
    jt_chk(16'h1234, 8'hFF);
    jt_chk(16'hFDFF, 8'hFF);
    $display("test full erase done");
    sfr_put(`FPES_SFR_STORE_CTL, 8'h01);
    op(1'b0, 1'b0, 16'h0100, 8'h5A, 0);
    cm_chk(16'h0100, 16'h0000, 8'hFF);
    @(negedge sys_clk);
    xm_rd = 1'b1;
    #1 `CHK("external_data_ram_rd", 1'b1, external_data_ram_rd)
    @(negedge sys_clk);
    xm_rd = 1'b0;
    $display("test write gate done");
    sfr_put(`FPES_SFR_FLASH_CTL, 8'h81);
    op(1'b0, 1'b0, 16'h0100, 8'h5A, 8);
    cm_chk(16'h0100, 16'h0000, 8'h5A);
    op(1'b0, 1'b0, 16'h0100, 8'h0F, 8);
    cm_chk(16'h0100, 16'h0000, 8'h0A);
    op(1'b0, 1'b0, 16'h0200, 8'h33, 8);
    $display("test byte write done");
    sfr_put(`FPES_SFR_STORE_CTL, 8'h03);
    op(1'b0, 1'b0, 16'h0155, 8'h00, 513);
    cm_chk(16'h0100, 16'h0000, 8'hFF);
    cm_chk(16'h0200, 16'h0000, 8'h33);
    op(1'b0, 1'b0, 16'hFC10, 8'h00, 0);
    sfr_put(`FPES_SFR_STORE_CTL, 8'h01);
    sfr_chk(`FPES_SFR_STORE_CTL, 8'h01);
    op(1'b0, 1'b0, `FPES_WE_LOCK_ADDR, 8'hFE, 8);
    jt_chk(`FPES_WE_LOCK_ADDR, 8'hFE);
    op(1'b0, 1'b0, `FPES_WE_LOCK_ADDR, 8'hFF, 8);
    jt_chk(`FPES_WE_LOCK_ADDR, 8'hFE);
    $display("test page erase done");
    sfr_put(`FPES_SFR_STORE_CTL, 8'h07);
    op(1'b0, 1'b0, 16'h0010, 8'h00, 129);
    sfr_put(`FPES_SFR_STORE_CTL, 8'h05);
    op(1'b0, 1'b0, 16'h0010, 8'h77, 8);
    cm_chk(16'h0010, 16'h0000, 8'h77);
    fetch_addr = 16'h0010;
    repeat (2) @(negedge sys_clk);
    `CHK("fetch_data", 8'hFF, fetch_data)
    sfr_put(`FPES_SFR_STORE_CTL, 8'h01);
    cm_chk(16'h0010, 16'h0000, 8'hFF);
    $display("test scratch sector done");
    op(1'b1, 1'b0, 16'h0000, 8'h00, 0);
    op(1'b1, 1'b0, 16'h2000, 8'h12, 8);
    jt_chk(16'h2000, 8'h12);
    op(1'b1, 1'b0, `FPES_RD_LOCK_ADDR, 8'hFD, 8);
    jt_chk(16'h2000, 8'h00);
    jt_chk(`FPES_RD_LOCK_ADDR, 8'hFD);
    // port page erase clears one page and leaves the page at 2000 untouched
    op(1'b1, 1'b0, 16'h4010, 8'h00, 8);
    op(1'b1, 1'b1, 16'h4010, 8'h00, 513);
    cm_chk(16'h4010, 16'h0000, 8'hFF);
    cm_chk(16'h2000, 16'h0000, 8'h12);
    // scratch stays open while any lock bit is still one
    jt_scr = 1'b1;
    op(1'b1, 1'b0, 16'h0010, 8'h33, 8);
    jt_chk(16'h0010, 8'h33);
    jt_scr = 1'b0;
    // lock bytes remain writable and readable with block 7 locked
    op(1'b1, 1'b0, `FPES_WE_LOCK_ADDR, 8'h00, 8);
    op(1'b1, 1'b0, `FPES_RD_LOCK_ADDR, 8'h7F, 8);
    jt_chk(`FPES_RD_LOCK_ADDR, 8'h7D);
    jt_scr = 1'b1;
    op(1'b1, 1'b0, 16'h0010, 8'h00, 0);
    jt_scr = 1'b0;
    $display("test port locks done");
    sfr_put(`FPES_SFR_ACC_LIMIT, 8'h40);
    sfr_put(`FPES_SFR_ACC_LIMIT, 8'h10);
    sfr_chk(`FPES_SFR_ACC_LIMIT, 8'h40);
    cm_chk(16'h2000, 16'h1000, 8'h12);
    cm_chk(16'h2000, 16'h5000, 8'h00);
    op(1'b0, 1'b0, 16'h0300, 8'h00, 0);
    op(1'b0, 1'b0, 16'h4100, 8'hF0, 8);
    $display("test access limit done");
    summarize();
  end
endmodule

/* File: testbench/fpes_jtag_host.sv */
`timescale 1ns/1ps
// programming port master model, strobes launched off the falling edge
module fpes_jtag_host (
  // clock
  input  wire logic                   sys_clk,
  // request to the device
  output fpes_pkg::fpes_jtag_req_type jtag_req
);
  initial jtag_req = '0;
  // one-cycle request; afterwards address and data are inverted so a
  // stale value held on the port can never pass for a live one
  task automatic send(input fpes_pkg::fpes_jtag_req_type req);
    @(negedge sys_clk);
    jtag_req = req;
    @(negedge sys_clk);
    jtag_req = {4'h0, ~req.addr, ~req.data};
  endtask
endmodule
